// ==== verif/rtc_audio_powerup_state_tb.sv ====
// Purpose: Self-checking bench for power-up state and audio control registers.
// Assumes: Registers are reached only through the two-wire host model.
// Notes:   Three power-ups: first, later with backup, then first again.

`timescale 1ns/1ps

// ==========================================================================
// Bench top
module rtc_audio_powerup_state_tb;
  import rtcaud_pkg::*;
  logic CLOCK, RST, BACKUP_VALID, OSC_FAIL_DETECT, slow, scl, host_oe, sda;
  logic SDA_O, SDA_OE, OUT_O, OUT_OE, AUDIO_ENABLE, TONE_INSERT, TONE_512, OSC_RUN;
  logic UPDATE_HALT, FREQ_TEST_EN, OSC_FAIL, TRICKLE_ON, DIODE_BYPASS;
  logic [3:0] VOLUME;
  logic signed [7:0] GAIN_DB;
  logic [5:0] CAL_VALUE;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  // Open-drain wire with pull-up.
  assign sda = (SDA_OE ? SDA_O : 1'b1) & ~host_oe;

  rtcaud_top u_rtcaud_top (.CLOCK(CLOCK), .RST(RST), .BACKUP_VALID(BACKUP_VALID),
    .OSC_FAIL_DETECT(OSC_FAIL_DETECT), .SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE), .OUT_O(OUT_O), .OUT_OE(OUT_OE), .VOLUME(VOLUME), .GAIN_DB(GAIN_DB),
    .AUDIO_ENABLE(AUDIO_ENABLE), .TONE_INSERT(TONE_INSERT), .TONE_512(TONE_512),
    .OSC_RUN(OSC_RUN), .UPDATE_HALT(UPDATE_HALT), .FREQ_TEST_EN(FREQ_TEST_EN),
    .OSC_FAIL(OSC_FAIL), .CAL_VALUE(CAL_VALUE), .TRICKLE_ON(TRICKLE_ON),
    .DIODE_BYPASS(DIODE_BYPASS));

  rtcaud_host_model u_rtcaud_host_model (.clock(CLOCK), .slow(slow), .sda_in(sda),
    .scl(scl), .sda_oe(host_oe));

  // Clock generator.
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run needs about 27k cycles; a hang is cut well after that.
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      $display("[ERR] %0t run hung", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    u_rtcaud_host_model.write_reg(p, d, ok);
    chb(ok, 1'b1);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_rtcaud_host_model.read_reg(p, d, ok);
    chb(ok, 1'b1);
    chk(d, e);
  endtask

  // Backup level is settled before reset falls; traffic waits past the init window.
  task automatic power_up(input logic bv);
    @(posedge CLOCK);
    #1;
    BACKUP_VALID = bv;
    RST = 1'b1;
    repeat (20) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    repeat (12) @(posedge CLOCK);
    #1;
  endtask

  task automatic check_first();
    chk({4'h0, VOLUME}, 8'h00);
    chk(GAIN_DB, 8'hdf);
    chb(AUDIO_ENABLE, 1'b0);
    chb(TONE_512, 1'b1);
    chb(TONE_INSERT, 1'b0);
    chb(OSC_RUN, 1'b1);
    chb(UPDATE_HALT, 1'b1);
    chb(FREQ_TEST_EN, 1'b0);
    chb(OSC_FAIL, 1'b1);
    chk({2'h0, CAL_VALUE}, 8'h00);
    chb(OUT_OE, 1'b0);
    chb(OUT_O, 1'b0);
    chb(TRICKLE_ON, 1'b0);
    chb(DIODE_BYPASS, 1'b0);
    rd(OFS_AUDIO_VOL, 8'h50);
    rd(OFS_TRICKLE, 8'h0a);
  endtask

  // Main sequence.
  initial begin
    RST = 1'b1;
    BACKUP_VALID = 1'b0;
    OSC_FAIL_DETECT = 1'b0;
    slow = 1'b0;
    power_up(1'b0);
    check_first();
    $display("test first power-up done");
    for (int i = 0; i < 16; i++) begin
      wr(OFS_AUDIO_VOL, 8'(i));
      chk({4'h0, VOLUME}, 8'(i));
      chk(GAIN_DB, 8'(3 * i - 33));
      chb(AUDIO_ENABLE, 1'b1);
    end
    rd(OFS_AUDIO_VOL, 8'h0f);
    $display("test gain sweep done");
    wr(OFS_AUDIO_VOL, 8'h1f);
    chb(AUDIO_ENABLE, 1'b0);
    slow = 1'b1;
    wr(OFS_AUDIO_VOL, 8'h6b);
    slow = 1'b0;
    chb(TONE_INSERT, 1'b1);
    chb(TONE_512, 1'b1);
    chk(GAIN_DB, 8'h00);
    wr(OFS_AUDIO_VOL, 8'h2b);
    chb(TONE_512, 1'b0);
    $display("test mute and tone done");
    wr(OFS_CAL_CTRL, 8'h75);
    chk({2'h0, CAL_VALUE}, 8'h35);
    chb(FREQ_TEST_EN, 1'b1);
    chb(OUT_OE, 1'b1);
    wr(OFS_TRICKLE, 8'h6a);
    chb(TRICKLE_ON, 1'b0);
    wr(OFS_TRICKLE, 8'h65);
    chb(TRICKLE_ON, 1'b1);
    chb(DIODE_BYPASS, 1'b1);
    wr(OFS_HALT_FLAGS, 8'h00);
    chb(UPDATE_HALT, 1'b0);
    OSC_FAIL_DETECT = 1'b1;
    @(posedge CLOCK);
    #1;
    OSC_FAIL_DETECT = 1'b0;
    repeat (3) @(posedge CLOCK);
    #1;
    chb(OSC_FAIL, 1'b1);
    wr(OFS_HALT_FLAGS, 8'h00);
    chb(OSC_FAIL, 1'b0);
    wr(OFS_OSC_CTRL, 8'h80);
    chb(OSC_RUN, 1'b0);
    wr(OFS_AUDIO_VOL, 8'h27);
    rd(8'h05, 8'h00);
    $display("test control bits done");
    // A frame for another slave address must go unanswered.
    begin : wrong_addr
      logic ack;
      u_rtcaud_host_model.start();
      u_rtcaud_host_model.put(8'h56, ack);
      u_rtcaud_host_model.stop();
      chb(ack, 1'b0);
    end
    power_up(1'b1);
    chk({4'h0, VOLUME}, 8'h07);
    chb(AUDIO_ENABLE, 1'b0);
    chb(TONE_INSERT, 1'b0);
    chb(TONE_512, 1'b0);
    chb(OSC_RUN, 1'b0);
    chb(UPDATE_HALT, 1'b1);
    chb(FREQ_TEST_EN, 1'b0);
    chb(OSC_FAIL, 1'b0);
    chk({2'h0, CAL_VALUE}, 8'h35);
    chb(OUT_OE, 1'b1);
    chb(TRICKLE_ON, 1'b0);
    chb(DIODE_BYPASS, 1'b0);
    rd(OFS_TRICKLE, 8'h0a);
    $display("test later power-up done");
    power_up(1'b0);
    check_first();
    $display("test repeated first power-up done");
    wrap_up();
  end
endmodule // rtc_audio_powerup_state_tb

// ==== verif/rtcaud_host_model.sv ====
// Purpose: Behavioural two-wire bus host that drives the register bank.
// Assumes: SDA has a pull-up; the bench resolves the wire from both enables.
// Notes:   SCL is push-pull and stands high outside frames.

`timescale 1ns/1ps

// ==========================================================================
// Host model
module rtcaud_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Target address, arbitrary value.
) (
  input  wire logic clock,   // Bench clock.
  input  wire logic slow,    // Doubles every bus phase when high.
  input  wire logic sda_in,  // Resolved SDA level.
  output logic      scl,     // Serial clock.
  output logic      sda_oe   // High pulls SDA low.
);
  // Idle bus: both lines released high.
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Signals move just after an edge; phases stay well above the slave's sync lag.
  task automatic tick(input int n);
    repeat (slow ? 2 * n : n) @(posedge clock);
    #1;
  endtask

  task automatic start();
    sda_oe = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_oe = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(4);
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_oe = 1'b0;
    tick(10);
  endtask

  // One bit: data set while SCL is low, sampled at the end of the high phase.
  task automatic xbit(input logic b, output logic r);
    sda_oe = ~b;
    tick(10);
    scl = 1'b1;
    tick(10);
    r = sda_in;
    scl = 1'b0;
    tick(4);
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(last, r);
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put({DEV_ADDR, 1'b0}, a0);
    put(p, a1);
    put(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Pointer set in one frame, single byte read and refused with NACK in the next.
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put({DEV_ADDR, 1'b0}, a0);
    put(p, a1);
    stop();
    start();
    put({DEV_ADDR, 1'b1}, a2);
    get(1'b1, d);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // rtcaud_host_model

// ==== verilog/rtcaud_pkg.sv ====
// Purpose: Shared constants for the clock-chip control register bank.
// Assumes: Byte-wide registers reached over a two-wire serial bus.
// Notes:   Offsets are byte pointers of the serial register file.

// ==========================================================================
// Package
package rtcaud_pkg;
  // Register pointers.
  localparam logic [7:0] OFS_OSC_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CAL_CTRL   = 8'h07;
  localparam logic [7:0] OFS_AUDIO_VOL  = 8'h08;
  localparam logic [7:0] OFS_TRICKLE    = 8'h09;
  localparam logic [7:0] OFS_HALT_FLAGS = 8'h0a;
  // Field positions.
  localparam int BIT_OSC_STOP    = 7;
  localparam int BIT_OUT_LEVEL   = 7;
  localparam int BIT_FREQ_TEST   = 6;
  localparam int BIT_CAL_SIGN    = 5;
  localparam int BIT_TONE_SEL    = 6;
  localparam int BIT_TONE_EN     = 5;
  localparam int BIT_MUTE        = 4;
  localparam int BIT_DIODE_BYP   = 6;
  localparam int BIT_TRICKLE_SW  = 5;
  localparam int BIT_UPDATE_HALT = 6;
  localparam int BIT_OSC_FAIL    = 2;
  // Power-up values, charger enable key and unmapped read value.
  localparam logic [3:0] TRICKLE_KEY_OFF = 4'ha;
  localparam logic [3:0] TRICKLE_KEY_ON  = 4'h5;
  localparam logic [3:0] GAIN_FIRST      = 4'h0;
  localparam logic [4:0] CAL_FIRST       = 5'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  // Gain law: dB = STEP * code + BASE.
  localparam logic signed [7:0] GAIN_STEP_DB = 8'sh03;
  localparam logic signed [7:0] GAIN_BASE_DB = -8'sh21;
  // Cycles allowed for the backup-status pin to settle after reset.
  // It must cover the three-flop synchroniser and the agreement stage.
  // Otherwise a later power-up would be taken for a first one.
  localparam logic [2:0] INIT_WAIT = 3'h5;
  // Serial slave states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } rtcaud_state_t;
endpackage

// ==== verilog/rtcaud_top.sv ====
// Purpose: Control register bank with audio volume, mute, tone and power-up state.
// Assumes: RST marks each power-up; BACKUP_VALID tells whether backup kept state.
// Notes:   Retained fields have no reset, like backup-powered storage.

`timescale 1ns/1ps

// Function
// - Volume code comes from bits 3..0 of the audio register at 0x08.
// - Volume codes map linearly, 3 dB steps, code 0 is -33 dB.
// - Bit 4 silences the audio regardless of volume code.
// - First power-up clears volume code and sets silence.
// - Later power-ups keep volume code but always set silence.
// - Tone insertion replaces input signal with 256 or 512 Hz tone.
// - Oscillator stop cleared on first power-up, kept afterwards.
// - Update halt set on every power-up; host clears it to resume.
// - Discrete output bit set on first power-up, kept afterwards.
// - Frequency test enable cleared on every power-up.
// - Oscillator fail flag set on first power-up, kept afterwards.
// - Every power-up clears trickle switch and bypass, key becomes hex A.
// - First power-up selects 512 Hz; every power-up clears tone insertion.
// - Calibration value and sign cleared first time, kept afterwards.
// - Bits with no given initial value are undefined after first power-up.
// - Calibration magnitude in bits 4..0 of 0x07, sign in bit 5.
module rtcaud_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Bus address, arbitrary value.
) (
  input  wire logic              CLOCK,           // 100 MHz clock.
  input  wire logic              RST,             // Async power-up reset.
  input  wire logic              BACKUP_VALID,    // Retained state is valid.
  input  wire logic              OSC_FAIL_DETECT, // Oscillator stop pulse.
  input  wire logic              SCL_I,           // Serial clock in.
  input  wire logic              SDA_I,           // Serial data in.
  output logic                   SDA_O,           // Serial data out, always 0.
  output logic                   SDA_OE,          // Serial data pull-low enable.
  output logic                   OUT_O,           // Discrete pin level, always 0.
  output logic                   OUT_OE,          // Discrete pin pull-low enable.
  output logic [3:0]             VOLUME,          // Active volume code.
  output logic signed [7:0]      GAIN_DB,         // Gain in dB.
  output logic                   AUDIO_ENABLE,    // Audio driver on.
  output logic                   TONE_INSERT,     // Tone replaces input.
  output logic                   TONE_512,        // Tone is 512 Hz, else 256.
  output logic                   OSC_RUN,         // Oscillator running.
  output logic                   UPDATE_HALT,     // Buffer updates frozen.
  output logic                   FREQ_TEST_EN,    // Frequency test output on.
  output logic                   OSC_FAIL,        // Oscillator fail flag.
  output logic [5:0]             CAL_VALUE,       // Sign and magnitude.
  output logic                   TRICKLE_ON,      // Charger switch closed.
  output logic                   DIODE_BYPASS     // Diode bypass closed.
);
  import rtcaud_pkg::*;

  // ========================================================================
  // Register state
  logic        osc_stop, out_level, freq_test, cal_sign, tone_sel, tone_en, mute;
  logic        diode_bypass, trickle_switch, update_halt, osc_fail;
  logic [4:0]  cal;
  logic [3:0]  gain, trickle_key;
  logic        wr_stb;
  logic [7:0]  wr_addr, wr_data;

  function automatic logic signed [7:0] gain_db(input logic [3:0] code);
    gain_db = 8'(GAIN_STEP_DB * $signed({4'h0, code}) + GAIN_BASE_DB);
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    unique case (a)
      OFS_OSC_CTRL:   read_reg = {osc_stop, 7'h00};
      OFS_CAL_CTRL:   read_reg = {out_level, freq_test, cal_sign, cal};
      OFS_AUDIO_VOL:  read_reg = {1'b0, tone_sel, tone_en, mute, gain};
      OFS_TRICKLE:    read_reg = {1'b0, diode_bypass, trickle_switch, 1'b0, trickle_key};
      OFS_HALT_FLAGS: read_reg = {1'b0, update_halt, 3'h0, osc_fail, 2'h0};
      default:        read_reg = READ_ZERO;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a);
    hit = wr_stb && (wr_addr == a);
  endfunction

  // ========================================================================
  // Power-up sequencing
  // Three-stage synchroniser on the backup status; only stages 2 and 3 are used.
  logic [2:0] bk_sync;
  logic       backup_ok;
  logic [2:0] init_cnt;
  logic       init_done, init_stb;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bk_sync <= 3'h0;
    end else begin
      bk_sync <= {bk_sync[1:0], BACKUP_VALID};
    end
  end

  // The level counts only once stages 2 and 3 agree.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      backup_ok <= 1'b0;
    end else if (bk_sync[1] == bk_sync[2]) begin
      backup_ok <= bk_sync[2];
    end
  end

  // Wait for the status to settle before deciding first or later power-up.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      init_cnt  <= 3'h0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt  <= 3'(init_cnt + 3'h1);
      init_done <= (init_cnt == INIT_WAIT);
    end
  end
  assign init_stb = !init_done && (init_cnt == INIT_WAIT);

  // ========================================================================
  // Fields forced on every power-up
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      update_halt    <= 1'b1;
      freq_test      <= 1'b0;
      mute           <= 1'b1;
      tone_en        <= 1'b0;
      trickle_switch <= 1'b0;
      diode_bypass   <= 1'b0;
      trickle_key    <= TRICKLE_KEY_OFF;
    end else begin
      if (hit(OFS_HALT_FLAGS)) update_halt <= wr_data[BIT_UPDATE_HALT];
      if (hit(OFS_CAL_CTRL))   freq_test   <= wr_data[BIT_FREQ_TEST];
      if (hit(OFS_AUDIO_VOL)) begin
        mute    <= wr_data[BIT_MUTE];
        tone_en <= wr_data[BIT_TONE_EN];
      end
      if (hit(OFS_TRICKLE)) begin
        trickle_switch <= wr_data[BIT_TRICKLE_SW];
        diode_bypass   <= wr_data[BIT_DIODE_BYP];
        trickle_key    <= wr_data[3:0];
      end
    end
  end

  // Retained fields: no reset, loaded only on a first power-up or by writes.
  always_ff @(posedge CLOCK) begin
    if (init_stb && !backup_ok) begin
      osc_stop  <= 1'b0;
      out_level <= 1'b1;
      gain      <= GAIN_FIRST;
      tone_sel  <= 1'b1;
      cal       <= CAL_FIRST;
      cal_sign  <= 1'b0;
    end else begin
      if (hit(OFS_OSC_CTRL)) osc_stop <= wr_data[BIT_OSC_STOP];
      if (hit(OFS_CAL_CTRL)) begin
        out_level <= wr_data[BIT_OUT_LEVEL];
        cal_sign  <= wr_data[BIT_CAL_SIGN];
        cal       <= wr_data[4:0];
      end
      if (hit(OFS_AUDIO_VOL)) begin
        gain     <= wr_data[3:0];
        tone_sel <= wr_data[BIT_TONE_SEL];
      end
    end
  end

  // Hardware set beats a software clear arriving in the same cycle.
  always_ff @(posedge CLOCK) begin
    if ((init_stb && !backup_ok) || OSC_FAIL_DETECT) begin
      osc_fail <= 1'b1;
    end else if (hit(OFS_HALT_FLAGS)) begin
      osc_fail <= wr_data[BIT_OSC_FAIL];
    end
  end

  // ========================================================================
  // Outputs
  assign VOLUME       = gain;
  assign GAIN_DB      = gain_db(gain);
  assign AUDIO_ENABLE = !mute;
  assign TONE_INSERT  = tone_en;
  assign TONE_512     = tone_sel;
  assign OSC_RUN      = !osc_stop;
  assign UPDATE_HALT  = update_halt;
  assign FREQ_TEST_EN = freq_test;
  assign OSC_FAIL     = osc_fail;
  assign CAL_VALUE    = {cal_sign, cal};
  assign TRICKLE_ON   = trickle_switch && (trickle_key == TRICKLE_KEY_ON);
  assign DIODE_BYPASS = diode_bypass;
  assign OUT_O        = 1'b0;
  assign OUT_OE       = !out_level;
  assign SDA_O        = 1'b0;

  // ========================================================================
  // Serial slave
  // Three flops per line; a level is accepted once stages 2 and 3 agree.
  logic [2:0] scl_s, sda_s;
  logic       scl, sda, scl_q, sda_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl   <= 1'b1;
      sda   <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], SCL_I};
      sda_s <= {sda_s[1:0], SDA_I};
      if (scl_s[1] == scl_s[2]) scl <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda <= sda_s[2];
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_c  = scl && scl_q && sda_q && !sda;
  assign stop_c   = scl && scl_q && !sda_q && sda;

  rtcaud_state_t state;
  logic [7:0]    sh, ptr;
  logic [3:0]    bitcnt;
  logic          nack;
  logic [7:0]    rd_byte;

  // Byte that a read would return from the current pointer.
  assign rd_byte = read_reg(ptr);

  // Bus protocol; register writes leave as a one-cycle strobe.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state   <= ST_IDLE;
      sh      <= 8'h00;
      ptr     <= 8'h00;
      bitcnt  <= 4'h0;
      nack    <= 1'b0;
      SDA_OE  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (!init_done || stop_c) begin
        state  <= ST_IDLE;
        SDA_OE <= 1'b0;
      end else if (start_c) begin
        state  <= ST_ADDR;
        bitcnt <= 4'h0;
        SDA_OE <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            sh     <= {sh[6:0], sda};
            bitcnt <= 4'(bitcnt + 4'h1);
          end
          ST_RDATA:     bitcnt <= 4'(bitcnt + 4'h1);
          ST_RDATA_ACK: nack   <= sda;
          ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: ;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          ST_IDLE: ;
          ST_ADDR: if (bitcnt == 4'h8) begin
            if (sh[7:1] == DEV_ADDR) begin
              state  <= ST_ADDR_ACK;
              nack   <= sh[0];
              SDA_OE <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_PTR: if (bitcnt == 4'h8) begin
            ptr    <= sh;
            state  <= ST_PTR_ACK;
            SDA_OE <= 1'b1;
          end
          ST_WDATA: if (bitcnt == 4'h8) begin
            wr_stb  <= 1'b1;
            wr_addr <= ptr;
            wr_data <= sh;
            ptr     <= 8'(ptr + 8'h1);
            state   <= ST_WDATA_ACK;
            SDA_OE  <= 1'b1;
          end
          ST_ADDR_ACK, ST_RDATA_ACK: begin
            bitcnt <= 4'h0;
            if (state == ST_ADDR_ACK && !nack) begin
              state  <= ST_PTR;
              SDA_OE <= 1'b0;
            end else if (state == ST_RDATA_ACK && nack) begin
              state  <= ST_IDLE;
              SDA_OE <= 1'b0;
            end else begin
              // Load the addressed byte and drive its top bit.
              sh     <= rd_byte;
              SDA_OE <= !rd_byte[7];
              ptr    <= 8'(ptr + 8'h1);
              state  <= ST_RDATA;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            bitcnt <= 4'h0;
            state  <= ST_WDATA;
            SDA_OE <= 1'b0;
          end
          ST_RDATA: if (bitcnt == 4'h8) begin
            state  <= ST_RDATA_ACK;
            SDA_OE <= 1'b0;
          end else begin
            sh     <= {sh[6:0], 1'b0};
            SDA_OE <= !sh[6];
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Assertions
  AST_GAIN_MAP: assert property (@(posedge CLOCK) disable iff (RST)
    init_done |-> GAIN_DB == 8'(3 * int'(VOLUME) - 33))
    else $error("Gain does not follow the 3 dB law.");
  AST_MUTE_CUT: assert property (@(posedge CLOCK) disable iff (RST)
    hit(OFS_AUDIO_VOL) && wr_data[BIT_MUTE] |=> !AUDIO_ENABLE)
    else $error("Audio enabled while silenced.");
  AST_VOL_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
    hit(OFS_AUDIO_VOL) |=> VOLUME == $past(wr_data[3:0]))
    else $error("Volume write not taken.");
  AST_CAL_WRITE: assert property (@(posedge CLOCK) disable iff (RST)
    hit(OFS_CAL_CTRL) |=> CAL_VALUE == $past(wr_data[5:0]))
    else $error("Calibration write not taken.");
  AST_FIRST_INIT: assert property (@(posedge CLOCK) disable iff (RST)
    init_stb && !backup_ok |=> VOLUME == 4'h0 && !AUDIO_ENABLE && OSC_RUN && !OUT_OE
      && OSC_FAIL && TONE_512 && CAL_VALUE == 6'h00)
    else $error("First power-up values wrong.");
  AST_LATER_KEEP: assert property (@(posedge CLOCK) disable iff (RST)
    init_stb && backup_ok |=> $stable(VOLUME) && $stable(CAL_VALUE) && $stable(TONE_512)
      && !AUDIO_ENABLE)
    else $error("Retained field changed on later power-up.");
  AST_ALWAYS_INIT: assert property (@(posedge CLOCK) disable iff (RST)
    init_stb |-> UPDATE_HALT && !FREQ_TEST_EN && !TONE_INSERT && !TRICKLE_ON
      && !DIODE_BYPASS && trickle_key == 4'ha)
    else $error("Power-up forced values wrong.");
  AST_TRICKLE: assert property (@(posedge CLOCK) disable iff (RST)
    TRICKLE_ON |-> trickle_switch && trickle_key == 4'h5)
    else $error("Charger closed without key.");
  AST_OF_SET: assert property (@(posedge CLOCK) disable iff (RST)
    OSC_FAIL_DETECT |=> OSC_FAIL)
    else $error("Oscillator fail flag not set.");
  AST_SETTLE: assert property (@(posedge CLOCK) disable iff (RST)
    init_stb |-> $past(bk_sync[2], 1) == backup_ok)
    else $error("Backup status not settled.");

  COV_FIRST: cover property (@(posedge CLOCK) disable iff (RST) init_stb && !backup_ok);
  COV_LATER: cover property (@(posedge CLOCK) disable iff (RST) init_stb && backup_ok);
  COV_VOLW:  cover property (@(posedge CLOCK) disable iff (RST) hit(OFS_AUDIO_VOL));
  COV_READ:  cover property (@(posedge CLOCK) disable iff (RST) state == ST_RDATA_ACK);
endmodule // rtcaud_top
